// ==== fault_history_auto_retry.sv ====
/*
  fault history (four entries) and automatic fault retry with a six second delay,
  reached over Avalon-MM word registers. assumes fault reports and run state come
  from logic on ref_clk_i; panel button and reset terminal are asynchronous pins.
*/
`timescale 1ns/1ps
`include "fault_retry_consts.svh"

// Overview of operation
// - four history entries, codes 0-60, reset zero
// - retry limit 0-10, zero disables retry
// - running fault with retry enabled auto-clears
// - beyond limit, panel button clears or terminal re-arms retry
// - reset terminal zeroes retry count
// - wait six seconds before auto clear
// - standby faults never auto-clear
// - panel source: clear then restart
// - terminal source: clear, resume current mode
// - history clear setting wipes all entries
// - codes 0-4 panel comm, hardware trips
// - codes 5-11 thermal, bus, mismatch faults
// - codes 12-14 per-phase loss or sensor
// - codes 16-18 encoder and tuning faults
// - code 19 tracking error over 40 turns
// - code 20 overload 150 percent 60 s
// - codes 21-23 encoder, analog, feedback loss
// - code 24 torque control overspeed
// - codes 25-28 parameter storage faults
// - codes 29-33, 35, 36 external and supply
// - codes 15, 34, 37-60 reserved
module fault_history_auto_retry
  import fault_retry_pkg::*;
(
  input wire logic ref_clk_i, // 10 MHz system clock
  input wire logic sys_rst_i, // synchronous reset, active high
  input wire logic clk_en_i, // freezes all state while low
  input wire logic [3:0] avs_address_i, // word index
  input wire logic avs_read_i, // read strobe
  input wire logic avs_write_i, // write strobe
  input wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // low when access completes
  input wire logic fault_valid_i, // one-cycle fault report
  input wire logic [7:0] fault_code_i, // reported fault code
  input wire logic fault_voltage_i, // 1 voltage trip, 0 current trip
  input wire logic drive_running_i, // drive is running, not standby
  input wire logic panel_reset_button_i, // panel reset pin, async
  input wire logic multi_input_four_i, // reset clearance terminal, async
  output logic fault_active_o, // drive is tripped
  output logic fault_clear_o, // one-cycle clear of the trip
  output logic restart_run_o, // one-cycle restart request (panel source)
  output logic resume_mode_o, // one-cycle resume request (terminal source)
  output logic fault_voltage_o, // latest trip was voltage kind
  output logic retry_locked_o // retry locked; panel button clears, terminal re-arms a running trip
);

  bus_req_type req;
  fault_event_type evt;
  logic [7:0] history [0:3];
  logic [7:0] auto_retry_limit;
  logic [7:0] fault_history_clear;
  run_source_type run_command_source;
  logic [7:0] retry_count;
  logic [31:0] delay_count;
  retry_state_type state;
  logic [1:0] button_sync;
  logic [1:0] terminal_sync;
  logic button_prev;
  logic terminal_prev;
  logic button_press;
  logic terminal_press;
  logic fault_from_run;
  logic ack;

  assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i, writedata: avs_writedata_i};
  assign evt = '{valid: fault_valid_i, code: fault_code_i, voltage_kind: fault_voltage_i};

  // reserved or out-of-range codes are not logged, so the history only holds assigned faults
  function automatic logic code_assigned(input logic [7:0] code);
    logic ok;
    ok = 1'b1;
    if (code > `FAULT_CODE_MAX) begin
      ok = 1'b0;
    end else if (code == `CODE_RESERVED_A || code == `CODE_RESERVED_B) begin
      ok = 1'b0;
    end else if (code > `CODE_DUP_INPUT) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // operand clamp used by the retry limit and history clear settings
  function automatic logic [7:0] clamp(input logic [31:0] value, input logic [7:0] max);
    logic [7:0] res;
    res = max;
    if (value <= {24'h000000, max}) begin
      res = value[7:0];
    end
    return res;
  endfunction

  // one-hot register select, shared by the read and the write paths
  function automatic logic [7:0] reg_select(input logic [3:0] address);
    logic [7:0] sel_bits;
    sel_bits = 8'h00;
    if (address == `ADDR_FAULT_NEWEST) begin
      sel_bits = 8'h01;
    end else if (address == `ADDR_FAULT_PREV_ONE) begin
      sel_bits = 8'h02;
    end else if (address == `ADDR_FAULT_PREV_TWO) begin
      sel_bits = 8'h04;
    end else if (address == `ADDR_FAULT_PREV_THREE) begin
      sel_bits = 8'h08;
    end else if (address == `ADDR_RETRY_LIMIT) begin
      sel_bits = 8'h10;
    end else if (address == `ADDR_HISTORY_CLEAR) begin
      sel_bits = 8'h20;
    end else if (address == `ADDR_RETRY_STATUS) begin
      sel_bits = 8'h40;
    end else if (address == `ADDR_RUN_SOURCE) begin
      sel_bits = 8'h80;
    end
    return sel_bits;
  endfunction

  logic [7:0] sel;
  logic [31:0] next_readdata;
  assign sel = reg_select(req.address);

  // a code reaches the history through the same check as the retry logic
  logic new_fault;
  assign new_fault = evt.valid && code_assigned(evt.code);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      button_sync <= 2'b00;
      terminal_sync <= 2'b00;
      button_prev <= 1'b0;
      terminal_prev <= 1'b0;
    end else if (clk_en_i) begin
      button_sync <= {button_sync[0], panel_reset_button_i};
      terminal_sync <= {terminal_sync[0], multi_input_four_i};
      button_prev <= button_sync[1];
      terminal_prev <= terminal_sync[1];
    end
  end

  assign button_press = button_sync[1] && !button_prev;
  assign terminal_press = terminal_sync[1] && !terminal_prev;

  // bus: every access completes in the cycle after it is raised
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ack <= 1'b0;
    end else if (clk_en_i) begin
      ack <= (req.read || req.write) && !ack;
    end
  end

  assign avs_waitrequest_o = (req.read || req.write) && !ack;

  always_comb begin
    next_readdata = 32'h00000000;
    if (sel[0]) begin
      next_readdata = {24'h000000, history[0]};
    end else if (sel[1]) begin
      next_readdata = {24'h000000, history[1]};
    end else if (sel[2]) begin
      next_readdata = {24'h000000, history[2]};
    end else if (sel[3]) begin
      next_readdata = {24'h000000, history[3]};
    end else if (sel[4]) begin
      next_readdata = {24'h000000, auto_retry_limit};
    end else if (sel[5]) begin
      next_readdata = {24'h000000, fault_history_clear};
    end else if (sel[6]) begin
      next_readdata = {20'h00000, 2'b00, state, fault_voltage_o, fault_active_o, retry_count[5:0]};
    end else if (sel[7]) begin
      next_readdata = {31'h00000000, run_command_source};
    end
  end

  // read data is captured in the wait cycle so it stands when waitrequest drops
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (clk_en_i && req.read && !ack) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // settings; out-of-range retry limit and history clear writes saturate at the top of the range, run source takes bit 0
  // a write lands only at the edge where waitrequest is seen low
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      auto_retry_limit <= `FIELD_RESET;
      fault_history_clear <= `FIELD_RESET;
      run_command_source <= src_panel;
    end else if (clk_en_i && req.write && ack) begin
      if (sel[4]) begin
        auto_retry_limit <= clamp(req.writedata, `RETRY_LIMIT_MAX);
      end else if (sel[5]) begin
        fault_history_clear <= clamp(req.writedata, `HISTORY_CLEAR_MAX);
      end else if (sel[7]) begin
        run_command_source <= run_source_type'(req.writedata[0]);
      end
    end
  end

  // history: a new fault wins over the clear setting in the same cycle
  generate
    for (genvar i = 0; i < 4; i++) begin : g_hist
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          history[i] <= `FIELD_RESET;
        end else if (clk_en_i) begin
          if (new_fault) begin
            if (i == 0) begin
              history[i] <= evt.code;
            end else begin
              history[i] <= history[i-1];
            end
          end else if (fault_history_clear == `HISTORY_CLEAR_MAX) begin
            history[i] <= `FIELD_RESET;
          end
        end
      end
    end
  endgenerate

  // events shared by the state, flag, delay and counter blocks below
  logic manual_clear;
  logic delay_done;
  logic auto_clear;
  logic retry_allowed;
  logic rearm;

  // the panel button clears any trip; a fault in the same cycle wins
  assign manual_clear = button_press && fault_active_o && !new_fault;
  assign delay_done = (delay_count >= `RETRY_DELAY_CYC - 1);
  assign auto_clear = (state == st_wait) && delay_done && !new_fault && !manual_clear;
  // limit zero never retries; a count that has reached the limit blocks retry
  assign retry_allowed = (auto_retry_limit != `FIELD_RESET) && (retry_count < auto_retry_limit);
  // terminal clear lets a still-pending running trip resume retrying
  assign rearm = (state == st_locked) && terminal_press && fault_from_run
                 && (auto_retry_limit != `FIELD_RESET) && !new_fault && !manual_clear;

  // trip sequencing
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= st_idle;
    end else if (clk_en_i) begin
      if (new_fault) begin
        if (drive_running_i && retry_allowed) begin
          state <= st_wait;
        end else begin
          state <= st_locked;
        end
      end else if (manual_clear) begin
        state <= st_idle;
      end else begin
        case (state)
          st_wait: begin
            if (auto_clear) begin
              state <= st_idle;
            end
          end
          st_locked: begin
            if (rearm) begin
              state <= st_wait;
            end
          end
          st_idle: begin
            state <= st_idle;
          end
          default: begin
            state <= st_idle;
          end
        endcase
      end
    end
  end

  // trip flag: set by a logged fault, dropped by either kind of clear
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fault_active_o <= 1'b0;
    end else if (clk_en_i) begin
      if (new_fault) begin
        fault_active_o <= 1'b1;
      end else if (manual_clear || auto_clear) begin
        fault_active_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fault_voltage_o <= 1'b0;
    end else if (clk_en_i && new_fault) begin
      fault_voltage_o <= evt.voltage_kind;
    end
  end

  // remembers whether the pending trip came from a running drive
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fault_from_run <= 1'b0;
    end else if (clk_en_i && new_fault) begin
      fault_from_run <= drive_running_i;
    end
  end

  // retry delay; a newer fault restarts it
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      delay_count <= 32'h00000000;
    end else if (clk_en_i) begin
      if (new_fault || rearm) begin
        delay_count <= 32'h00000000;
      end else if (state == st_wait && !delay_done && !manual_clear) begin
        delay_count <= delay_count + 32'h00000001;
      end
    end
  end

  // one-cycle clear, restart and resume pulses
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fault_clear_o <= 1'b0;
      restart_run_o <= 1'b0;
      resume_mode_o <= 1'b0;
    end else if (clk_en_i) begin
      fault_clear_o <= manual_clear || auto_clear;
      restart_run_o <= auto_clear && (run_command_source == src_panel);
      resume_mode_o <= auto_clear && (run_command_source == src_terminal);
    end
  end

  // retry count: terminal clear wins over a simultaneous increment
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      retry_count <= 8'h00;
    end else if (clk_en_i) begin
      if (terminal_press) begin
        retry_count <= 8'h00;
      end else if (auto_clear && retry_count != 8'hff) begin
        retry_count <= retry_count + 8'h01;
      end
    end
  end

  assign retry_locked_o = (state == st_locked);

endmodule

// ==== fault_retry_consts.svh ====
/*
  offsets, field limits, fault codes, reset values and timing counts for the fault history
  and automatic retry block; assumes a 10 MHz clock and a 32-bit Avalon-MM bus.
*/
`ifndef FAULT_RETRY_CONSTS_SVH
`define FAULT_RETRY_CONSTS_SVH

`define ADDR_FAULT_NEWEST 4'h0
`define ADDR_FAULT_PREV_ONE 4'h1
`define ADDR_FAULT_PREV_TWO 4'h2
`define ADDR_FAULT_PREV_THREE 4'h3
`define ADDR_RETRY_LIMIT 4'h4
`define ADDR_HISTORY_CLEAR 4'h5
`define ADDR_RETRY_STATUS 4'h6
`define ADDR_RUN_SOURCE 4'h7

`define FAULT_CODE_MAX 8'h3c
`define RETRY_LIMIT_MAX 8'h0a
`define HISTORY_CLEAR_MAX 8'h01
`define FIELD_RESET 8'h00

`define CODE_PANEL_COMM 8'h00
`define CODE_HW_LAST 8'h04
`define CODE_HEATSINK 8'h05
`define CODE_RATING_MISMATCH 8'h0b
`define CODE_PHASE_FIRST 8'h0c
`define CODE_PHASE_LAST 8'h0e
`define CODE_RESERVED_A 8'h0f
`define CODE_ENCODER_DIR 8'h10
`define CODE_TRACKING 8'h13
`define CODE_OVERLOAD 8'h14
`define CODE_OVERSPEED 8'h18
`define CODE_STORAGE_LAST 8'h1c
`define CODE_EXT_INPUT 8'h1d
`define CODE_MAINS 8'h21
`define CODE_RESERVED_B 8'h22
`define CODE_DUP_INPUT 8'h24

`define CLK_HZ 10000000
`define RETRY_DELAY_S 6
`define RETRY_DELAY_CYC (`RETRY_DELAY_S * `CLK_HZ)

`endif

// ==== fault_retry_pkg.sv ====
/*
  types for the fault history and automatic retry block; no assumptions beyond
  a synthesizable SystemVerilog tool flow.
*/
package fault_retry_pkg;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_locked = 2'b10
  } retry_state_type;

  typedef enum logic {
    src_panel = 1'b0,
    src_terminal = 1'b1
  } run_source_type;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } bus_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic voltage_kind;
  } fault_event_type;

endpackage

// ==== fault_retry_monitor.sv ====
/*
  assertion checker for the fault history and retry block.
  assumes one clock and a synchronous active-high reset; bound to the block's ports.
*/
`timescale 1ns/1ps
module fault_retry_monitor (
  input wire logic ref_clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic clk_en_i, // clock enable
  input wire logic fault_valid_i, // fault report
  input wire logic [7:0] fault_code_i, // fault code
  input wire logic fault_voltage_i, // fault kind
  input wire logic drive_running_i, // run state
  input wire logic panel_reset_button_i, // panel button
  input wire logic fault_active_o, // trip present
  input wire logic fault_clear_o, // clear pulse
  input wire logic restart_run_o, // restart pulse
  input wire logic resume_mode_o, // resume pulse
  input wire logic fault_voltage_o, // trip kind
  input wire logic retry_locked_o // locked
);
  logic [4:0] btn_hist;
  logic quiet;
  logic assigned;
  // the button passes a synchronizer, so quiet must cover its whole latency
  always_ff @(posedge ref_clk_i) begin
    btn_hist <= {btn_hist[3:0], panel_reset_button_i};
  end
  assign quiet = (btn_hist == 5'h00) && !panel_reset_button_i;
  assign assigned = fault_valid_i && clk_en_i && fault_code_i <= 8'h24 && fault_code_i != 8'h0f
    && fault_code_i != 8'h22;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_ACCEPT: assert property (assigned |=> fault_active_o)
    else $error("assigned fault not latched");
  AST_RESERVED: assert property (fault_valid_i && clk_en_i && !assigned && !fault_active_o |=> !fault_active_o)
    else $error("reserved code raised a trip");
  AST_STANDBY_LOCK: assert property (assigned && !drive_running_i |=> retry_locked_o)
    else $error("standby fault not locked");
  AST_LOCK_HOLDS: assert property ($past(retry_locked_o) && quiet |-> !fault_clear_o)
    else $error("locked trip cleared without button");
  AST_KIND: assert property (assigned |=> fault_voltage_o == $past(fault_voltage_i))
    else $error("trip kind wrong");
  AST_CLEAR_PULSE: assert property (fault_clear_o && clk_en_i |=> !fault_clear_o)
    else $error("clear pulse too long");
  AST_CLEAR_ENDS: assert property (fault_clear_o && !$past(fault_valid_i) |-> !fault_active_o)
    else $error("trip still active after clear");
  AST_RESTART_CLEAR: assert property (restart_run_o || resume_mode_o |-> fault_clear_o && !retry_locked_o)
    else $error("restart without clear");
  AST_ONE_MODE: assert property (!(restart_run_o && resume_mode_o))
    else $error("restart and resume together");
endmodule
bind fault_history_auto_retry fault_retry_monitor u_mon (.ref_clk_i, .sys_rst_i, .clk_en_i, .fault_valid_i,
  .fault_code_i, .fault_voltage_i, .drive_running_i, .panel_reset_button_i, .fault_active_o, .fault_clear_o,
  .restart_run_o, .resume_mode_o, .fault_voltage_o, .retry_locked_o);

// ==== panel_terminal_model.sv ====
/*
  model of the operator panel button and the reset clearance terminal.
  assumes the block synchronizes both pins, so each press is held four cycles.
*/
`timescale 1ns/1ps
module panel_terminal_model (
  input wire logic ref_clk_i, // clock
  output logic panel_reset_button_o, // panel reset button
  output logic multi_input_four_o // reset clearance terminal
);
  initial begin
    panel_reset_button_o = 1'b0;
    multi_input_four_o = 1'b0;
  end
  task automatic press(input bit term);
    @(posedge ref_clk_i);
    if (term) begin
      multi_input_four_o <= 1'b1;
    end else begin
      panel_reset_button_o <= 1'b1;
    end
    repeat (4) @(posedge ref_clk_i);
    multi_input_four_o <= 1'b0;
    panel_reset_button_o <= 1'b0;
  endtask
endmodule

// ==== fault_history_auto_retry_tb.sv ====
/*
  self-checking bench for the fault history and retry block.
  assumes the six second delay cannot elapse in a short run, so auto clears are left to the checker.
*/
`timescale 1ns/1ps
module fault_history_auto_retry_tb;
  import fault_retry_pkg::*;
  logic ref_clk_i, sys_rst_i, fault_valid_i, fault_voltage_i, drive_running_i, btn, term;
  logic clk_en;
  logic [7:0] fault_code_i;
  logic [31:0] rd;
  bus_req_type req;
  wire logic [31:0] avs_readdata_o;
  wire logic avs_waitrequest_o, fault_active_o, fault_voltage_o, retry_locked_o;
  int error_cnt = 0;
  int total_checks = 0;
  fault_history_auto_retry dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
    .avs_address_i(req.address), .avs_read_i(req.read), .avs_write_i(req.write),
    .avs_writedata_i(req.writedata), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .fault_valid_i(fault_valid_i), .fault_code_i(fault_code_i), .fault_voltage_i(fault_voltage_i),
    .drive_running_i(drive_running_i), .panel_reset_button_i(btn), .multi_input_four_i(term),
    .fault_active_o(fault_active_o), .fault_clear_o(), .restart_run_o(), .resume_mode_o(),
    .fault_voltage_o(fault_voltage_o), .retry_locked_o(retry_locked_o));
  panel_terminal_model panel (.ref_clk_i(ref_clk_i), .panel_reset_button_o(btn), .multi_input_four_o(term));
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic finish_test;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // the request stands until waitrequest is seen low; no latency is assumed
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    req <= '{address: a, read: !wr, write: wr, writedata: d};
    // look at waitrequest mid-cycle, then act on the edge that samples it low
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    @(posedge ref_clk_i);
    rd = avs_readdata_o;
    req <= '{default: '0};
    if (n >= 20) error_cnt++;
  endtask
  task automatic expect_reg(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check($sformatf("register %0h", a), rd, e);
  endtask
  task automatic hist_is(input logic [7:0] h0, input logic [7:0] h1, input logic [7:0] h2, input logic [7:0] h3);
    logic [7:0] h [4];
    h = '{h0, h1, h2, h3};
    for (int i = 0; i < 4; i++) expect_reg(i[3:0], {24'h0, h[i]});
  endtask
  task automatic fault(input logic [7:0] c, input logic v);
    @(posedge ref_clk_i);
    fault_valid_i <= 1'b1;
    fault_code_i <= c;
    fault_voltage_i <= v;
    @(posedge ref_clk_i);
    fault_valid_i <= 1'b0;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    error_cnt++;
    finish_test();
  end
  initial begin
    logic [7:0] resv [4];
    resv = '{8'h0f, 8'h22, 8'h25, 8'h3c};
    sys_rst_i = 1'b1;
    req = '{default: '0};
    clk_en = 1'b1;
    fault_valid_i = 1'b0;
    fault_code_i = 8'h00;
    fault_voltage_i = 1'b0;
    drive_running_i = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) expect_reg(i[3:0], 32'h0);
    bus(1'b1, 4'h9, 32'hff);
    expect_reg(4'h9, 32'h0);
    bus(1'b1, 4'h4, 32'h0b);
    expect_reg(4'h4, 32'h0a);
    bus(1'b1, 4'h5, 32'h02);
    expect_reg(4'h5, 32'h01);
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h5, 32'h0);
    fault(8'h05, 1'b0);
    fault(8'h0c, 1'b0);
    fault(8'h13, 1'b0);
    fault(8'h24, 1'b1);
    @(negedge ref_clk_i);
    check("locked", {fault_active_o, fault_voltage_o, retry_locked_o}, 3'b111);
    for (int i = 0; i < 4; i++) fault(resv[i], 1'b0);
    fault(8'h18, 1'b0);
    hist_is(8'h18, 8'h24, 8'h13, 8'h0c);
    panel.press(1'b0);
    expect_reg(4'h6, 32'h0);
    drive_running_i <= 1'b1;
    fault(8'h00, 1'b1);
    expect_reg(4'h6, 32'h2c0);
    bus(1'b1, 4'h4, 32'h03);
    panel.press(1'b1);
    expect_reg(4'h6, 32'h1c0);
    hist_is(8'h00, 8'h18, 8'h24, 8'h13);
    clk_en <= 1'b0;
    fault(8'h01, 1'b0);
    clk_en <= 1'b1;
    hist_is(8'h00, 8'h18, 8'h24, 8'h13);
    bus(1'b1, 4'h5, 32'h01);
    hist_is(8'h00, 8'h00, 8'h00, 8'h00);
    bus(1'b1, 4'h7, 32'h01);
    expect_reg(4'h7, 32'h01);
    finish_test();
  end
endmodule
